// [core/frc_pkg.sv]
// Package of constants for the filter restart and conversion timing block
package frc_pkg;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SYS_PERIOD_PS = 244141;
    localparam int SYS_DIV       = (SYS_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int MOD_DIV_SYS   = 16;
    localparam int MUL_DIV_SYS   = 2;
    localparam logic [1:0] SYNC_DELAY_SYS = 2'h2;
    localparam logic [1:0] SYNC_PULSE_MUL = 2'h2;
    localparam logic [1:0] ISEL_PULSE_SYS = 2'h2;
    localparam logic [1:0] RCMD_PULSE_SYS = 2'h2;
    localparam logic [5:0] CFG_PULSE_MOD  = 6'h20;
    localparam logic [5:0] START_HOLD_MOD = 6'h20;
    localparam int NUM_RATES = 10;
    localparam int CNT_W     = 20;
    // Index 0..9 = 5, 10, 20, 40, 80, 160, 320, 640, 1000, 2000 SPS
    localparam logic [CNT_W-1:0] FIRST_FAST [NUM_RATES] = '{
        20'd816188, 20'd408124, 20'd204092, 20'd102076, 20'd51068,
        20'd25564,  20'd12796,  20'd6428,   20'd4156,   20'd2108};
    localparam logic [CNT_W-1:0] FIRST_SLOW [NUM_RATES] = '{
        20'd820290, 20'd412226, 20'd208194, 20'd103106, 20'd52098,
        20'd26594,  20'd13314,  20'd6946,   20'd4674,   20'd2370};
    localparam logic [CNT_W-1:0] STEADY [NUM_RATES] = '{
        20'd816128, 20'd408064, 20'd204032, 20'd102016, 20'd51008,
        20'd25504,  20'd12736,  20'd6368,   20'd4096,   20'd2048};
endpackage

// [core/frc_tick_div.sv]
// Enable divider producing one-cycle ticks at a slower rate
`timescale 1ns/100ps
module frc_tick_div #(
    parameter int DIV = 2
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic en,
    output logic      tick
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          tick_next;

    initial begin
        if (DIV < 1) $error("frc_tick_div: DIV must be at least 1");
    end

    // Count enables, emit one tick per DIV of them
    always_comb begin
        cnt_next  = cnt_reg;
        tick_next = 1'b0;
        if (en) begin
            if (cnt_reg == CW'(DIV - 1)) begin
                cnt_next  = '0;
                tick_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            tick    <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick    <= tick_next;
        end
    end
endmodule // frc_tick_div

// [core/frc_core.sv]
// Filter restart sources, reset pulse timing and conversion length counter
`timescale 1ns/100ps
module frc_core #(
    parameter int SYS_DIV   = frc_pkg::SYS_DIV,
    parameter int MOD_DIV   = frc_pkg::MOD_DIV_SYS,
    parameter int MUL_DIV   = frc_pkg::MUL_DIV_SYS,
    parameter int CONV_SHIFT = 0
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       restart_cmd,
    input  wire logic       reset_cmd,
    input  wire logic       leave_sleep_command,
    input  wire logic       reset_pin_n,
    input  wire logic       start_pin,
    input  wire logic       wr_input_select,
    input  wire logic       wr_bias_voltage,
    input  wire logic       wr_reference_control,
    input  wire logic       wr_gain_rate,
    input  wire logic [3:0] rate_sel,
    output logic            filter_rst_n,
    output logic            conv_done,
    output logic            first_conv,
    output logic            slow_first
);
    localparam int CW = frc_pkg::CNT_W;

    initial begin
        if (CONV_SHIFT < 0 || CONV_SHIFT > 10) $error("frc_core: CONV_SHIFT out of range");
        if (SYS_DIV < 1 || MOD_DIV < 1 || MUL_DIV < 1) $error("frc_core: dividers must be >= 1");
    end

    // Conversion length in system ticks, shortened only for simulation
    function automatic logic [CW-1:0] conv_len(input logic [3:0] rate, input logic first,
                                               input logic slow);
        logic [3:0]    idx;
        logic [CW-1:0] len;
        idx = (rate > 4'h9) ? 4'h9 : rate;
        if (!first)
            len = frc_pkg::STEADY[idx];
        else if (slow)
            len = frc_pkg::FIRST_SLOW[idx];
        else
            len = frc_pkg::FIRST_FAST[idx];
        return len >> CONV_SHIFT;
    endfunction

    logic sys_tick;
    logic mod_tick;
    logic mul_tick;

    // Slower rates are tick enables cascaded from the system tick
    frc_tick_div #(
        .DIV   (SYS_DIV)
    ) u_sys (
        .clk   (clk),
        .rst_n (rst_n),
        .en    (1'b1),
        .tick  (sys_tick)
    );

    // Modulator tick; pulses that count it start with a partial period
    frc_tick_div #(
        .DIV   (MOD_DIV)
    ) u_mod (
        .clk   (clk),
        .rst_n (rst_n),
        .en    (sys_tick),
        .tick  (mod_tick)
    );

    // Multiplier tick, one clock behind the system tick that feeds it
    frc_tick_div #(
        .DIV   (MUL_DIV)
    ) u_mul (
        .clk   (clk),
        .rst_n (rst_n),
        .en    (sys_tick),
        .tick  (mul_tick)
    );

    logic [1:0]    sync_dly_reg,  sync_dly_next;
    logic [1:0]    sync_cnt_reg,  sync_cnt_next;
    logic [1:0]    isel_cnt_reg,  isel_cnt_next;
    logic [1:0]    rcmd_cnt_reg,  rcmd_cnt_next;
    logic [5:0]    cfg_cnt_reg,   cfg_cnt_next;
    logic [5:0]    start_cnt_reg, start_cnt_next;
    logic          start_prev_reg;
    logic          fast_src;
    logic          slow_src;
    logic          any_rst;

    // Per-source pulse counters; a new trigger reloads and so stretches the pulse
    always_comb begin
        sync_dly_next  = sync_dly_reg;
        sync_cnt_next  = sync_cnt_reg;
        isel_cnt_next  = isel_cnt_reg;
        rcmd_cnt_next  = rcmd_cnt_reg;
        cfg_cnt_next   = cfg_cnt_reg;
        start_cnt_next = start_cnt_reg;
        if (sync_cnt_reg != 2'h0 && mul_tick)
            sync_cnt_next = sync_cnt_reg - 2'h1;
        if (sync_dly_reg != 2'h0 && sys_tick) begin
            sync_dly_next = sync_dly_reg - 2'h1;
            if (sync_dly_reg == 2'h1)
                sync_cnt_next = frc_pkg::SYNC_PULSE_MUL;
        end
        if (restart_cmd)
            sync_dly_next = frc_pkg::SYNC_DELAY_SYS;
        if (isel_cnt_reg != 2'h0 && sys_tick)
            isel_cnt_next = isel_cnt_reg - 2'h1;
        if (wr_input_select)
            isel_cnt_next = frc_pkg::ISEL_PULSE_SYS;
        if (rcmd_cnt_reg != 2'h0 && sys_tick)
            rcmd_cnt_next = rcmd_cnt_reg - 2'h1;
        if (reset_cmd || leave_sleep_command)
            rcmd_cnt_next = frc_pkg::RCMD_PULSE_SYS;
        if (cfg_cnt_reg != 6'h00 && mod_tick)
            cfg_cnt_next = cfg_cnt_reg - 6'h01;
        if (wr_bias_voltage || wr_reference_control || wr_gain_rate)
            cfg_cnt_next = frc_pkg::CFG_PULSE_MOD;
        if (start_cnt_reg != 6'h00 && mod_tick)
            start_cnt_next = start_cnt_reg - 6'h01;
        if (start_pin && !start_prev_reg)
            start_cnt_next = frc_pkg::START_HOLD_MOD;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_dly_reg   <= 2'h0;
            sync_cnt_reg   <= 2'h0;
            isel_cnt_reg   <= 2'h0;
            rcmd_cnt_reg   <= 2'h0;
            cfg_cnt_reg    <= 6'h00;
            start_cnt_reg  <= 6'h00;
            start_prev_reg <= 1'b0;
        end else begin
            sync_dly_reg   <= sync_dly_next;
            sync_cnt_reg   <= sync_cnt_next;
            isel_cnt_reg   <= isel_cnt_next;
            rcmd_cnt_reg   <= rcmd_cnt_next;
            cfg_cnt_reg    <= cfg_cnt_next;
            start_cnt_reg  <= start_cnt_next;
            start_prev_reg <= start_pin;
        end
    end

    // AND of active-low pulses equals OR of active-high ones
    assign fast_src = (sync_cnt_reg != 2'h0) || (isel_cnt_reg != 2'h0);
    assign slow_src = !reset_pin_n || (rcmd_cnt_reg != 2'h0) || (cfg_cnt_reg != 6'h00)
                      || (start_cnt_reg != 6'h00);
    assign any_rst  = fast_src || slow_src;

    logic [CW-1:0] conv_cnt_reg, conv_cnt_next;
    logic          filt_next, done_next, first_next, slow_next, rst_prev_reg;

    // Conversion counter; the first length depends on which sources fired
    always_comb begin
        filt_next     = !any_rst;
        conv_cnt_next = conv_cnt_reg;
        done_next     = 1'b0;
        first_next    = first_conv;
        slow_next     = slow_first;
        if (any_rst) begin
            conv_cnt_next = '0;
            first_next    = 1'b1;
            // A slow source anywhere in the reset window wins
            slow_next     = (rst_prev_reg ? slow_first : 1'b0) | slow_src;
        end else if (sys_tick) begin
            if (conv_cnt_reg == conv_len(rate_sel, first_conv, slow_first) - 1'b1) begin
                conv_cnt_next = '0;
                done_next     = 1'b1;
                first_next    = 1'b0;
            end else begin
                conv_cnt_next = conv_cnt_reg + 1'b1;
            end
        end
    end

    // Power-on counts as a hardware reset: slow first conversion
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_cnt_reg <= '0;
            filter_rst_n <= 1'b0;
            conv_done    <= 1'b0;
            first_conv   <= 1'b1;
            slow_first   <= 1'b1;
            rst_prev_reg <= 1'b1;
        end else begin
            conv_cnt_reg <= conv_cnt_next;
            filter_rst_n <= filt_next;
            conv_done    <= done_next;
            first_conv   <= first_next;
            slow_first   <= slow_next;
            rst_prev_reg <= any_rst;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_pin_holds: assert property (!reset_pin_n |=> !filter_rst_n)
        else $error("filter not in reset while reset pin low");
    a_sync_delay: assert property (restart_cmd |=> sync_dly_reg == 2'h2)
        else $error("restart delay not armed");
    a_sync_pulse: assert property ((sync_dly_reg == 2'h1 && sys_tick && !restart_cmd)
        |=> sync_cnt_reg == 2'h2 ##1 !filter_rst_n)
        else $error("restart pulse not started");
    a_isel_pulse: assert property (wr_input_select |=> isel_cnt_reg == 2'h2
        ##1 !filter_rst_n)
        else $error("input-select write did not reset filter");
    a_cfg_pulse: assert property ((wr_bias_voltage || wr_reference_control || wr_gain_rate)
        |=> cfg_cnt_reg == 6'h20 ##1 (!filter_rst_n && slow_first))
        else $error("config write pulse wrong");
    a_rcmd_pulse: assert property ((reset_cmd || leave_sleep_command)
        |=> rcmd_cnt_reg == 2'h2 ##1 (!filter_rst_n && slow_first))
        else $error("reset or wake command did not reset filter");
    a_slow_class: assert property (slow_src |=> slow_first && first_conv)
        else $error("slow source did not select slow first conversion");
    a_and_combine: assert property ((fast_src || slow_src) |=> !filter_rst_n)
        else $error("active source did not hold filter");
    a_start_hold: assert property ($rose(start_pin) |=> start_cnt_reg == 6'h20)
        else $error("start rise did not arm 32 modulator hold");
    a_done_clears: assert property (conv_done |-> conv_cnt_reg == '0 && !first_conv)
        else $error("conversion end did not restart count");
    a_cnt_in_rst: assert property (!filter_rst_n |-> conv_cnt_reg == '0 && first_conv)
        else $error("counter ran during filter reset");

    c_restart: cover property (restart_cmd ##[1:1000] !filter_rst_n);
    c_first_done: cover property (conv_done && $past(first_conv));
    c_overlap: cover property (fast_src && slow_src);
    c_start_hold: cover property ($rose(start_pin) ##1 start_cnt_reg == 6'h20);
    c_pin_reset: cover property (!reset_pin_n ##1 !filter_rst_n);
endmodule // frc_core

// [dv/frc_host_model.sv]
// Host controller model issuing decoded commands and register writes as pulses
`timescale 1ns/100ps
module frc_host_model (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [2:0] code,
    output logic            restart_cmd,
    output logic            reset_cmd,
    output logic            leave_sleep_command,
    output logic            wr_input_select,
    output logic            wr_bias_voltage,
    output logic            wr_reference_control,
    output logic            wr_gain_rate
);
    // One decoded command or write per request, one clk wide; nothing held over
    always @(posedge clk) begin
        restart_cmd          <= go && (code == 3'h0);
        reset_cmd            <= go && (code == 3'h1);
        leave_sleep_command  <= go && (code == 3'h2);
        wr_input_select      <= go && (code == 3'h3);
        wr_bias_voltage      <= go && (code == 3'h4);
        wr_reference_control <= go && (code == 3'h5);
        wr_gain_rate         <= go && (code == 3'h6);
    end
endmodule // frc_host_model

// [dv/filter_reset_and_conversion_timing_tb.sv]
// Bench for the filter restart and conversion timing block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked++; if ((e) !== (g)) begin n_errors++; \
    $display("wrong value %s expected %0d seen %0d", nm, e, g); end end
module filter_reset_and_conversion_timing_tb;
    localparam int SD = 2;
    localparam int MD = 16;
    localparam int ML = 2;
    localparam int SH = 4;
    localparam int CFGW = 32 * MD * SD;
    logic clk = 1'b0, rst_n = 1'b0, go = 1'b0, reset_pin_n = 1'b1, start_pin = 1'b0;
    logic [2:0] code = 3'h0;
    logic [3:0] rate_sel = 4'h9;
    logic rcmd, rst_cmd, wake, wisel, wbias, wref, wgain;
    logic filter_rst_n, conv_done, first_conv, slow_first;
    int   n_errors = 0, samples_checked = 0, dly, wid, c;
    // Commands and writes reach the block through the host model; the reset and start pins are driven straight from the bench
    frc_host_model u_frc_host_model (.clk(clk), .go(go), .code(code), .restart_cmd(rcmd),
        .reset_cmd(rst_cmd), .leave_sleep_command(wake), .wr_input_select(wisel),
        .wr_bias_voltage(wbias), .wr_reference_control(wref), .wr_gain_rate(wgain));
    // Short tick dividers keep the run small; lengths scale with them
    frc_core #(.SYS_DIV(SD), .MOD_DIV(MD), .MUL_DIV(ML), .CONV_SHIFT(SH)) u_frc_core (
        .clk(clk), .rst_n(rst_n), .restart_cmd(rcmd), .reset_cmd(rst_cmd),
        .leave_sleep_command(wake), .reset_pin_n(reset_pin_n), .start_pin(start_pin),
        .wr_input_select(wisel), .wr_bias_voltage(wbias), .wr_reference_control(wref),
        .wr_gain_rate(wgain), .rate_sel(rate_sel), .filter_rst_n(filter_rst_n),
        .conv_done(conv_done), .first_conv(first_conv), .slow_first(slow_first));
    always #2.5 clk = ~clk;
    // Range check for figures whose tick phase is not fixed
    task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
        samples_checked++;
        if (g < lo || g > hi) begin
            n_errors++;
            $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    task automatic end_sim();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic send(input logic [2:0] k);
        @(posedge clk);
        go   <= 1'b1;
        code <= k;
        @(posedge clk);
        go   <= 1'b0;
    endtask
    // Delay to the fall of the filter reset, then its low width; both bounded
    task automatic measure(output int d, output int w);
        d = 0;
        w = 0;
        while (filter_rst_n !== 1'b0 && d < 3000) begin @(posedge clk); #1; d++; end
        while (filter_rst_n !== 1'b1 && w < 3000) begin @(posedge clk); #1; w++; end
        if (d >= 3000 || w >= 3000) begin n_errors++; end_sim(); end
    endtask
    task automatic wait_done(output int n);
        n = 0;
        do begin @(posedge clk); #1; n++; end while (conv_done !== 1'b1 && n < 3000);
        if (n >= 3000) begin n_errors++; end_sim(); end
    endtask
    // First conversion from release, then one steady conversion, both counted in clk cycles
    task automatic convs(input logic fast, input int r);
        int t1, t2, e1;
        e1 = (fast ? frc_pkg::FIRST_FAST[r] : frc_pkg::FIRST_SLOW[r]) >> SH;
        `CHK("slow_first", !fast, slow_first)
        `CHK("first_conv", 1'b1, first_conv)
        wait_done(t1);
        chk_rng("first length", e1 * SD - SD - 2, e1 * SD + SD + 2, t1);
        wait_done(t2);
        `CHK("steady length", (frc_pkg::STEADY[r] >> SH) * SD, t2)
        `CHK("first_conv", 1'b0, first_conv)
    endtask
    initial begin
        #500000;
        n_errors++;
        end_sim();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        `CHK("filter_rst_n", 1'b1, filter_rst_n)
        convs(1'b0, 9);
        // Repeated input-select writes each restart, value unseen
        send(3'h3);
        send(3'h3);
        measure(dly, wid);
        chk_rng("isel width", SD, 2 * SD + 2, wid);
        convs(1'b1, 9);
        rate_sel <= 4'h8;
        send(3'h0);
        measure(dly, wid);
        chk_rng("restart delay", SD, 2 * SD + 3, dly);
        chk_rng("restart width", ML * SD, 2 * ML * SD + 2, wid);
        convs(1'b1, 8);
        for (c = 1; c <= 2; c++) begin
            send(3'(c));
            measure(dly, wid);
            chk_rng("cmd width", SD, 2 * SD + 2, wid);
            convs(1'b0, 8);
        end
        for (c = 4; c <= 6; c++) begin
            send(3'(c));
            measure(dly, wid);
            chk_rng("cfg width", CFGW - MD * SD, CFGW + 3, wid);
            convs(1'b0, 8);
        end
        // Fast source inside a slow pulse must neither cut it short nor win
        send(3'h6);
        repeat (100) @(posedge clk);
        send(3'h3);
        measure(dly, wid);
        chk_rng("overlap rest", CFGW - MD * SD - 110, CFGW - 100, wid);
        convs(1'b0, 8);
        @(posedge clk);
        start_pin <= 1'b1;
        measure(dly, wid);
        chk_rng("start hold", CFGW - MD * SD, CFGW + 3, wid);
        convs(1'b0, 8);
        // Rate codes above the table act as the fastest rate
        rate_sel <= 4'hF;
        @(posedge clk);
        reset_pin_n <= 1'b0;
        repeat (20) @(posedge clk);
        reset_pin_n <= 1'b1;
        #1;
        `CHK("pin hold", 1'b0, filter_rst_n)
        measure(dly, wid);
        chk_rng("pin release", 0, 2, wid);
        convs(1'b0, 9);
        // A mid-table rate through a fast start
        rate_sel <= 4'h7;
        send(3'h3);
        measure(dly, wid);
        chk_rng("isel width", SD, 2 * SD + 2, wid);
        convs(1'b1, 7);
        end_sim();
    end
endmodule // filter_reset_and_conversion_timing_tb
